//--- core/twmc_pkg.sv
package twmc_pkg;
   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_MODE   = 8'h04;
   localparam logic [7:0] ADDR_WAVE   = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_RHR    = 8'h10;
   localparam logic [7:0] ADDR_THR    = 8'h14;
   localparam logic [7:0] ADDR_ISR    = 8'h18;
   localparam logic [7:0] ADDR_IMR    = 8'h1C;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CTRL_START   = 0;
   localparam int CTRL_ENABLE  = 2;
   localparam int CTRL_DISABLE = 3;
   localparam int CTRL_SWRST   = 7;
   localparam int MODE_READ    = 8;
   localparam int ST_TRANSFER_COMPLETE_FLAG    = 0;
   localparam int ST_RECEIVE_READY_FLAG     = 1;
   localparam int ST_TRANSMIT_READY_FLAG     = 2;
   localparam int ST_OVERRUN   = 6;
   localparam int ST_NACK      = 8;
   localparam int ST_WEDGED    = 9;
   localparam int ST_ENABLED   = 10;

   // ****************************************************************
   // Reset values and constants
   // ****************************************************************
   localparam logic [18:0] WAVE_RESET = 19'h0_0000;
   localparam logic [15:0] CNT_ONE    = 16'h0001;
   localparam logic [3:0]  ACK_BIT    = 4'h8;
   localparam logic [3:0]  LAST_BIT   = 4'h7;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [5:0] {
      S_IDLE  = 6'b00_0001,
      S_START = 6'b00_0010,
      S_LOW   = 6'b00_0100,
      S_HIGH  = 6'b00_1000,
      S_STOPL = 6'b01_0000,
      S_STOPH = 6'b10_0000
   } twmc_state_t;

   typedef struct packed {
      logic [2:0] expo;
      logic [7:0] high;
      logic [7:0] low;
   } twmc_wave_t;

   typedef struct packed {
      logic nack;
      logic receive_ready_flag;
      logic transfer_complete_flag;
   } twmc_events_t;
endpackage : twmc_pkg

//--- core/twmc_core.sv
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - Soft reset with clock low blocks transfers
// - Disable freezes transfer, keeps complete/ready flags
// - Status read before completion loses not-acknowledge
// - Complete and nack rise together; status read clears nack
// - Receive register loads on every data byte
// - Transmit overwrite sets no ready/overrun flag
module twmc_core import twmc_pkg::*; (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   output logic             irq
);
   // ****************************************************************
   // Bus slave
   // ****************************************************************
   logic        aw_held, w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic [31:0] rd_mux;
   logic        rd_map;
   wire         wr_go   = aw_held & w_held & ~s_axi_bvalid;
   wire  [31:0] wmask   = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire  [31:0] wbits   = w_data & wmask;
   wire         wr_ctrl = wr_go && aw_addr == ADDR_CTRL;
   wire         wr_mode = wr_go && aw_addr == ADDR_MODE;
   wire         wr_wave = wr_go && aw_addr == ADDR_WAVE;
   wire         wr_thr  = wr_go && aw_addr == ADDR_THR && w_strb[0];
   wire         wr_isr  = wr_go && aw_addr == ADDR_ISR;
   wire         wr_imr  = wr_go && aw_addr == ADDR_IMR;
   wire         wr_map  = wr_ctrl | wr_mode | wr_wave | (wr_go && aw_addr == ADDR_THR) | wr_isr | wr_imr;
   wire         rd_go   = s_axi_arvalid & s_axi_arready;
   wire         rd_stat = rd_go && s_axi_araddr == ADDR_STATUS;
   wire         rd_rhr  = rd_go && s_axi_araddr == ADDR_RHR;

   assign s_axi_awready = ~aw_held;
   assign s_axi_wready  = ~w_held;
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
         end else if (wr_go) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Control state and flags
   // ****************************************************************
   twmc_state_t  state;
   twmc_wave_t   wave;
   twmc_events_t isr, imr;
   logic [15:0]  cnt;
   logic [3:0]   bitc;
   logic [7:0]   shreg, thr, rhr;
   logic [6:0]   taddr;
   logic         rd, byte_idx, enabled, wedged;
   logic         transfer_complete_flag, transmit_ready_flag, receive_ready_flag, overrun, nack, nack_pending, nack_lost;
   logic         scl_s1, scl_s2, sda_s1, sda_s2;

   wire         sw_rst      = wr_ctrl & wbits[CTRL_SWRST];
   wire         srst        = ~aresetn | sw_rst;
   wire         dis_wr      = wr_ctrl & wbits[CTRL_DISABLE] & ~sw_rst;
   wire         run         = enabled & ~dis_wr;
   wire  [15:0] low_raw     = {8'h00, wave.low} << wave.expo;
   wire  [15:0] high_raw    = {8'h00, wave.high} << wave.expo;
   wire  [15:0] low_len     = (low_raw == 16'h0000) ? CNT_ONE : low_raw;
   wire  [15:0] high_len    = (high_raw == 16'h0000) ? CNT_ONE : high_raw;
   wire  [15:0] phase_len   = (state == S_LOW || state == S_STOPL) ? low_len : high_len;
   wire         phase_end   = cnt >= phase_len - CNT_ONE;
   wire         tx_byte     = ~byte_idx | ~rd;
   wire         sda_drv_low = (bitc < ACK_BIT) & tx_byte & ~shreg[7];
   wire         bit_end     = run && state == S_HIGH && scl_s2 && phase_end;
   wire         ack_end     = bit_end && bitc == ACK_BIT;
   wire         nack_det    = ack_end & tx_byte & sda_s2;
   wire         data_end    = bit_end && bitc == LAST_BIT && byte_idx;
   wire         rx_done     = data_end & rd;
   wire         thr_load    = ack_end & ~nack_det & ~byte_idx & ~rd;
   wire         frame_end   = run && state == S_STOPH && scl_s2 && phase_end;
   wire         start_ok    = wr_ctrl && wbits[CTRL_START] && run && !wedged && state == S_IDLE;
   wire         nack_set    = frame_end & nack_pending & ~nack_lost;
   wire twmc_events_t events = '{nack: nack_set, receive_ready_flag: rx_done, transfer_complete_flag: frame_end};

   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign irq     = |(isr & imr);

   always_comb begin
      rd_mux              = 32'h0000_0000;
      rd_map              = 1'b1;
      case (s_axi_araddr)
         ADDR_MODE: rd_mux = {23'h00_0000, rd, 1'b0, taddr};
         ADDR_WAVE: rd_mux = {13'h0000, wave};
         ADDR_STATUS: begin
            rd_mux[ST_TRANSFER_COMPLETE_FLAG]  = transfer_complete_flag;
            rd_mux[ST_RECEIVE_READY_FLAG]   = receive_ready_flag;
            rd_mux[ST_TRANSMIT_READY_FLAG]   = transmit_ready_flag;
            rd_mux[ST_OVERRUN] = overrun;
            rd_mux[ST_NACK]    = nack;
            rd_mux[ST_WEDGED]  = wedged;
            rd_mux[ST_ENABLED] = enabled;
         end
         ADDR_RHR:  rd_mux = {24'h00_0000, rhr};
         ADDR_ISR:  rd_mux = {29'h0000_0000, isr};
         ADDR_IMR:  rd_mux = {29'h0000_0000, imr};
         ADDR_CTRL, ADDR_THR: rd_mux = 32'h0000_0000;
         default:   rd_map = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
   end

   // Survives the soft reset; only the hardware reset clears it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wedged <= 1'b0;
      end else if (sw_rst && state != S_IDLE && scl_oe) begin
         wedged <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (srst) begin
         wave    <= WAVE_RESET;
         imr     <= '0;
         taddr   <= 7'h00;
         rd      <= 1'b0;
         thr     <= 8'h00;
         enabled <= 1'b0;
      end else begin
         if (wr_wave) wave <= twmc_wave_t'((wave & ~wmask[18:0]) | wbits[18:0]);
         if (wr_imr) imr <= twmc_events_t'(wbits[2:0]);
         if (wr_mode && w_strb[0]) taddr <= w_data[6:0];
         if (wr_mode && w_strb[1]) rd <= w_data[MODE_READ];
         if (wr_thr) thr <= w_data[7:0];
         if (dis_wr) enabled <= 1'b0;
         else if (wr_ctrl && wbits[CTRL_ENABLE]) enabled <= 1'b1;
      end
   end

   // Flags: hardware set wins over any read or write clear in the same cycle
   always_ff @(posedge aclk) begin
      if (srst) begin
         transfer_complete_flag       <= 1'b1;
         transmit_ready_flag        <= 1'b1;
         receive_ready_flag        <= 1'b0;
         overrun      <= 1'b0;
         nack         <= 1'b0;
         nack_pending <= 1'b0;
         nack_lost    <= 1'b0;
         isr          <= '0;
         rhr          <= 8'h00;
      end else begin
         if (frame_end) transfer_complete_flag <= 1'b1;
         else if (start_ok) transfer_complete_flag <= 1'b0;
         if (thr_load) transmit_ready_flag <= 1'b1;
         else if (wr_thr) transmit_ready_flag <= 1'b0;
         if (data_end) rhr <= {shreg[6:0], sda_s2};
         if (rx_done) receive_ready_flag <= 1'b1;
         else if (rd_rhr) receive_ready_flag <= 1'b0;
         if (rx_done && receive_ready_flag) overrun <= 1'b1;
         else if (rd_stat) overrun <= 1'b0;
         if (nack_set) nack <= 1'b1;
         else if (rd_stat) nack <= 1'b0;
         if (nack_det) nack_pending <= 1'b1;
         else if (start_ok) nack_pending <= 1'b0;
         if (rd_stat && nack_pending) nack_lost <= 1'b1;
         else if (start_ok) nack_lost <= 1'b0;
         isr <= (wr_isr ? (isr & ~twmc_events_t'(wbits[2:0])) : isr) | events;
      end
   end

   // ****************************************************************
   // Bus sequencer, frozen while disabled
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (srst) begin
         state    <= S_IDLE;
         cnt      <= 16'h0000;
         bitc     <= 4'h0;
         byte_idx <= 1'b0;
         shreg    <= 8'h00;
         scl_oe   <= 1'b0;
         sda_oe   <= 1'b0;
      end else if (run) begin
         case (state)
            S_IDLE: if (start_ok) begin
               state    <= S_START;
               sda_oe   <= 1'b1;
               cnt      <= 16'h0000;
               bitc     <= 4'h0;
               byte_idx <= 1'b0;
               shreg    <= {taddr, rd};
            end
            S_START: if (phase_end) begin
               state  <= S_LOW;
               scl_oe <= 1'b1;
               cnt    <= 16'h0000;
            end else cnt <= cnt + CNT_ONE;
            S_LOW: begin
               sda_oe <= sda_drv_low;
               if (phase_end) begin
                  state  <= S_HIGH;
                  scl_oe <= 1'b0;
                  cnt    <= 16'h0000;
               end else cnt <= cnt + CNT_ONE;
            end
            S_HIGH: if (!scl_s2) cnt <= 16'h0000;
            else if (phase_end) begin
               cnt    <= 16'h0000;
               scl_oe <= 1'b1;
               if (bitc < ACK_BIT) begin
                  shreg <= {shreg[6:0], sda_s2};
                  bitc  <= bitc + 4'h1;
                  state <= S_LOW;
               end else begin
                  bitc <= 4'h0;
                  if (nack_det || byte_idx) state <= S_STOPL;
                  else begin
                     byte_idx <= 1'b1;
                     shreg    <= thr;
                     state    <= S_LOW;
                  end
               end
            end else cnt <= cnt + CNT_ONE;
            S_STOPL: begin
               sda_oe <= 1'b1;
               if (phase_end) begin
                  state  <= S_STOPH;
                  scl_oe <= 1'b0;
                  cnt    <= 16'h0000;
               end else cnt <= cnt + CNT_ONE;
            end
            S_STOPH: if (!scl_s2) cnt <= 16'h0000;
            else if (phase_end) begin
               sda_oe <= 1'b0;
               state  <= S_IDLE;
            end else cnt <= cnt + CNT_ONE;
            default: state <= S_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_disable_mid;
      dis_wr && state != S_IDLE;
   endsequence
   sequence s_read_in_gap;
      nack_pending && !nack_set && !sw_rst && !start_ok ##0 rd_stat;
   endsequence

   freeze_hold_a: assert property (s_disable_mid |=> $stable(state) && $stable(cnt))
      else $error("transfer not frozen by disable");
   flags_kept_a: assert property (dis_wr |=> $stable(transfer_complete_flag) && $stable(transmit_ready_flag))
      else $error("complete or ready flag changed on disable");
   nack_with_comp_a: assert property ($rose(nack) |-> $rose(transfer_complete_flag))
      else $error("nack rose without transfer complete");
   nack_read_clear_a: assert property (rd_stat && !nack_set && !sw_rst |=> !nack)
      else $error("status read did not clear nack");
   nack_lost_a: assert property (s_read_in_gap |=> nack_lost)
      else $error("read in gap not recorded");
   nack_kept_low_a: assert property (nack_lost && frame_end |=> !nack)
      else $error("nack set after read in gap");
   wedge_block_a: assert property (wedged && wr_ctrl && wbits[CTRL_START] |=> state == S_IDLE)
      else $error("transfer started while wedged");
   tx_overwrite_a: assert property (data_end && !rd |=> rhr == $past({shreg[6:0], sda_s2}) && !$rose(receive_ready_flag))
      else $error("transmit byte load wrong");
   tx_no_overrun_a: assert property (data_end && !rd && !rx_done |=> !$rose(overrun))
      else $error("overrun set on transmit byte");
   low_drive_a: assert property (state == S_LOW |-> scl_oe)
      else $error("clock released in low phase");
endmodule : twmc_core

//--- bench/twmc_target_model.sv
`timescale 1ns/1ps
module twmc_target_model #(
   parameter logic [6:0] ADDR = 7'h2A
) (
   input  wire logic       aresetn,
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       nack_data,
   input  wire logic       slow,
   input  wire logic [7:0] rd_byte,
   output logic            scl_pull,
   output logic            sda_pull,
   output logic [7:0]      got_addr,
   output logic [7:0]      got_byte
);
   // ****************************************************************
   // Behavioural target
   // ****************************************************************
   logic [7:0] sh;
   logic       ack;

   always @(negedge aresetn) disable body;

   always begin : body
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      @(negedge sda iff scl === 1'b1);
      repeat (8) @(posedge scl) sh = {sh[6:0], sda};
      got_addr = sh;
      ack = (sh[7:1] == ADDR);
      @(negedge scl);
      sda_pull = ack;
      if (slow) begin
         // Stretch the clock low
         scl_pull = 1'b1;
         #200;
         scl_pull = 1'b0;
      end
      @(negedge scl);
      sda_pull = 1'b0;
      if (ack && sh[0]) begin
         for (int i = 7; i >= 0; i--) begin
            sda_pull = !rd_byte[i];
            @(negedge scl);
         end
         sda_pull = 1'b0;
      end else if (ack) begin
         repeat (8) @(posedge scl) sh = {sh[6:0], sda};
         got_byte = sh;
         @(negedge scl);
         sda_pull = !nack_data;
         @(negedge scl);
      end
   end
endmodule : twmc_target_model

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top import twmc_pkg::*; ;
   // ****************************************************************
   // Bench
   // ****************************************************************
   localparam logic [6:0] TADDR = 7'h2A;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, scl_oe, sda_oe, irq;
   logic        scl_pull, sda_pull, nack_data, slow;
   logic [7:0]  awaddr, araddr, rd_byte, got_addr, got_byte;
   logic [31:0] wdata, rdata, st, s0;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rsp;
   logic [1:0]  o;
   int          fails, cmp_count, cyc;
   wire         scl = !(scl_oe | scl_pull);
   wire         sda = !(sda_oe | sda_pull);

   twmc_core u_twmc_core (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .irq(irq));

   twmc_target_model #(.ADDR(TADDR)) u_twmc_target_model (.aresetn(aresetn), .scl(scl), .sda(sda),
      .nack_data(nack_data), .slow(slow), .rd_byte(rd_byte), .scl_pull(scl_pull), .sda_pull(sda_pull),
      .got_addr(got_addr), .got_byte(got_byte));

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      cyc++;
      if (cyc == 60000) begin
         fails++;
         end_sim();
      end
   end

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rsp = bresp;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      st = rdata;
      rsp = rresp;
   endtask : rd

   task automatic ctl(input int b);
      wr(ADDR_CTRL, 32'h0000_0001 << b);
   endtask : ctl

   task automatic go(input logic r, input logic [7:0] b);
      wr(ADDR_MODE, {23'h0, r, 1'b0, TADDR});
      wr(ADDR_THR, {24'h0, b});
      ctl(CTRL_START);
   endtask : go

   task automatic wirq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 4000) begin
         @(posedge aclk);
         n++;
      end
      check(irq, 1'b1);
   endtask : wirq

   task automatic rst;
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask : rst

   task automatic t_reset;
      rd(ADDR_STATUS);
      check(st, 32'h0000_0005);
      rd(8'h20);
      check(rsp, RESP_SLVERR);
      wr(8'h24, 32'h0000_0000);
      check(rsp, RESP_SLVERR);
      wr(ADDR_WAVE, 32'h0000_0F10);
      ctl(CTRL_ENABLE);
      wr(ADDR_IMR, 32'h0000_0007);
      $display("reset test done");
   endtask : t_reset

   task automatic t_write;
      go(1'b0, 8'hA5);
      wirq();
      check(got_addr, {TADDR, 1'b0});
      check(got_byte, 8'hA5);
      wr(ADDR_IMR, 32'h0000_0000);
      check(irq, 1'b0);
      wr(ADDR_IMR, 32'h0000_0007);
      check(irq, 1'b1);
      wr(ADDR_ISR, 32'h0000_0007);
      check(irq, 1'b0);
      $display("write test done");
   endtask : t_write

   task automatic t_read;
      slow <= 1'b1;
      rd_byte <= 8'h3C;
      go(1'b1, 8'h00);
      wirq();
      rd(ADDR_STATUS);
      check(st[ST_RECEIVE_READY_FLAG], 1'b1);
      rd(ADDR_RHR);
      check(st[7:0], 8'h3C);
      rd(ADDR_STATUS);
      check(st[ST_RECEIVE_READY_FLAG], 1'b0);
      wr(ADDR_ISR, 32'h0000_0007);
      slow <= 1'b0;
      $display("read test done");
   endtask : t_read

   task automatic t_rhr;
      rd_byte <= 8'h5A;
      go(1'b1, 8'h00);
      wirq();
      wr(ADDR_ISR, 32'h0000_0007);
      // Received byte left unread on purpose
      go(1'b0, 8'h96);
      wirq();
      rd(ADDR_STATUS);
      check(st[ST_OVERRUN], 1'b0);
      rd(ADDR_RHR);
      check(st[7:0], 8'h96);
      wr(ADDR_ISR, 32'h0000_0007);
      go(1'b0, 8'h69);
      wirq();
      rd(ADDR_STATUS);
      check({st[ST_OVERRUN], st[ST_RECEIVE_READY_FLAG]}, 2'b00);
      wr(ADDR_ISR, 32'h0000_0007);
      $display("holding register test done");
   endtask : t_rhr

   task automatic t_nack;
      nack_data <= 1'b1;
      go(1'b0, 8'h11);
      wirq();
      rd(ADDR_ISR);
      check(st[2:0], 3'b101);
      rd(ADDR_STATUS);
      check({st[ST_NACK], st[ST_TRANSFER_COMPLETE_FLAG]}, 2'b11);
      rd(ADDR_STATUS);
      check(st[ST_NACK], 1'b0);
      wr(ADDR_ISR, 32'h0000_0007);
      go(1'b0, 8'h22);
      repeat (10) @(posedge aclk);
      // Polling while busy on purpose
      do rd(ADDR_STATUS); while (st[ST_TRANSFER_COMPLETE_FLAG] !== 1'b1);
      check(st[ST_NACK], 1'b0);
      rd(ADDR_STATUS);
      check(st[ST_NACK], 1'b0);
      wr(ADDR_ISR, 32'h0000_0007);
      nack_data <= 1'b0;
      $display("nack test done");
   endtask : t_nack

   task automatic t_disable;
      go(1'b0, 8'h3C);
      repeat (150) @(posedge aclk);
      rd(ADDR_STATUS);
      s0 = st;
      // Disable mid-frame on purpose
      ctl(CTRL_DISABLE);
      o = {scl, sda};
      repeat (200) begin
         @(posedge aclk);
         check({scl, sda}, o);
      end
      rd(ADDR_STATUS);
      check({st[ST_TRANSMIT_READY_FLAG], st[ST_TRANSFER_COMPLETE_FLAG]}, {s0[ST_TRANSMIT_READY_FLAG], s0[ST_TRANSFER_COMPLETE_FLAG]});
      ctl(CTRL_ENABLE);
      wirq();
      check(got_byte, 8'h3C);
      wr(ADDR_ISR, 32'h0000_0007);
      wr(ADDR_IMR, 32'h0000_0000);
      ctl(CTRL_DISABLE);
      rd(ADDR_STATUS);
      check({st[ST_ENABLED], st[ST_TRANSFER_COMPLETE_FLAG]}, 2'b01);
      wr(ADDR_IMR, 32'h0000_0007);
      ctl(CTRL_ENABLE);
      $display("disable test done");
   endtask : t_disable

   task automatic t_wedge;
      go(1'b0, 8'h77);
      @(posedge scl_oe);
      @(posedge aclk);
      ctl(CTRL_SWRST);
      rd(ADDR_STATUS);
      check(st[ST_WEDGED], 1'b1);
      ctl(CTRL_ENABLE);
      go(1'b0, 8'h01);
      repeat (300) begin
         @(posedge aclk);
         check({scl_oe, sda_oe}, 2'b00);
      end
      rst();
      rd(ADDR_STATUS);
      check(st[ST_WEDGED], 1'b0);
      $display("wedge test done");
   endtask : t_wedge

   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, arvalid, nack_data, slow} = 5'b0_0000;
      {bready, rready} = 2'b11;
      wstrb = 4'hF;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0000_0000;
      rd_byte = 8'h00;
      rst();
      t_reset();
      t_write();
      t_read();
      t_rhr();
      t_nack();
      t_disable();
      t_wedge();
      end_sim();
   end
endmodule : tb_top
